// >>> sbhf_map.svh
`ifndef SBHF_MAP_SVH
`define SBHF_MAP_SVH

// synchroniser lanes, one per pin input
`define SBHF_IN_FLUSH 0
`define SBHF_IN_HOLD 1
`define SBHF_IN_STROBE 2
`define SBHF_IN_ROLE 3
`define SBHF_IN_PINS 4

// own output pins as compared in checker role
`define SBHF_PIN_HIT 0
`define SBHF_PIN_SNOOP_HIT_MODIFIED_OUT 1
`define SBHF_PIN_FP_ERROR_OUT 2
`define SBHF_PIN_ACK 3
`define SBHF_PIN_BT 4
`define SBHF_OWN_PINS 5

// reset levels
`define SBHF_RST_NEG_B 1'b1
`define SBHF_RST_LOW 1'b0

`endif

// >>> sbhf_pkg.sv
package sbhf_pkg;

	typedef enum logic [4:0] {
		FL_IDLE = 5'h01,
		FL_WB = 5'h02,
		FL_INV = 5'h04,
		FL_ACK = 5'h08,
		FL_DONE = 5'h10
	} sbhf_flush_t;

	typedef enum logic [2:0] {
		HD_IDLE = 3'h1,
		HD_WAIT = 3'h2,
		HD_HELD = 3'h4
	} sbhf_hold_t;

endpackage

// >>> sbhf_sync_if.sv
`timescale 1ns/1ps
interface sbhf_sync_if #(
	parameter int W = 4
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;

	modport sync (
		input raw,
		output clean
	);

	modport user (
		output raw,
		input clean
	);
endinterface

// >>> sbhf_insync.sv
`timescale 1ns/1ps
module sbhf_insync #(
	parameter int W = 4
) (
	input wire logic clk, // device clock
	sbhf_sync_if.sync sif // raw pins in, filtered levels out
);
	// no reset: the chain must keep running while reset is applied
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_q;
	logic [W-1:0] agree;

	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk) begin
		s1_q <= sif.raw;
		s2_q <= s1_q;
		s3_q <= s2_q;
		clean_q <= (agree & s2_q) | (~agree & clean_q);
	end

	assign sif.clean = clean_q;
endmodule

// >>> sbhf_ctrl.sv
`timescale 1ns/1ps
`include "sbhf_map.svh"
// Functional notes
// - drive fp error pin on unmasked error
// - flush writes back modified, then invalidates caches
// - flush ends with acknowledge special cycle
// - flush low at reset release: tristate test
// - master role drives pins normally
// - checker floats outputs except internal error
// - role latched at reset, held until next
// - snoop hit asserted two clocks after strobe
// - snoop miss negates hit two clocks after
// - hit changes only on inquire cycles
// - hit-modified asserted after modified line hit
// - hold: finish cycles, float, then acknowledge
// - bus stays floated while hold remains
// - hold ignored during locked cycles
// - hold answered even during reset
// - pending cycle starts when acknowledge drops
// - branch pulse high exactly one clock
// - branch pulse driven during hold too
// - checker mismatch raises error two clocks later
module sbhf_ctrl import sbhf_pkg::*; #(
	parameter int CW = 8 // core outputs compared in checker role
) (
	input wire logic clk, // 50 MHz device clock
	input wire logic rst_b, // asynchronous reset
	input wire logic flush_b_pin, // cache flush request pin
	input wire logic hold_pin, // bus hold request pin
	input wire logic snoop_addr_strobe_b, // inquire address strobe pin
	input wire logic redundancy_role_sel_b, // low selects checker role
	output logic snoop_lookup_req, // pulse: look up snoop address
	input wire logic snoop_lookup_hit, // lookup hit a valid line
	input wire logic snoop_lookup_hit_mod, // lookup hit a modified line
	input wire logic snoop_wb_done, // pulse: snooped line written back
	output logic flush_wb_req, // level: write back modified lines
	input wire logic flush_wb_done, // pulse: flush writebacks finished
	output logic cache_inv_req, // pulse: invalidate both caches
	output logic flush_ack_cyc_req, // level: run flush ack cycle
	input wire logic flush_ack_cyc_done, // pulse: flush ack cycle done
	input wire logic bus_busy, // bus cycles outstanding
	input wire logic bus_locked, // locked sequence in progress
	output logic bus_start_ok, // core may start a bus cycle
	output logic bus_pins_oe_b, // high floats the bus pins
	input wire logic fp_err_unmasked, // unmasked fp error pending
	input wire logic branch_taken_evt, // one cycle per taken branch
	output logic snoop_hit_b, // hit pin
	output logic snoop_hit_oe_b, // hit pin enable
	output logic snoop_hit_modified_out_b, // hit-modified pin
	output logic snoop_snoop_hit_modified_out_oe_b, // hit-modified pin enable
	output logic fp_error_out_b, // fp error pin
	output logic fp_error_oe_b, // fp error pin enable
	output logic bus_grant_ack, // hold acknowledge pin
	output logic bus_grant_ack_oe_b, // hold acknowledge pin enable
	output logic branch_taken_pulse, // branch taken pin
	output logic branch_taken_oe_b, // branch taken pin enable
	output logic internal_error_out_b, // internal error pin
	output logic internal_error_oe_b, // internal error pin enable
	input wire logic [`SBHF_OWN_PINS-1:0] own_pin_in, // own pin levels
	input wire logic [CW-1:0] core_pin_exp, // core outputs computed
	input wire logic [CW-1:0] core_pin_in, // core pin levels
	output logic tristate_test, // tristate test mode latched
	output logic checker_mode // checker role latched
);
	localparam int PW = `SBHF_OWN_PINS + CW;

	sbhf_sync_if #(.W(`SBHF_IN_PINS)) in_if ();

	assign in_if.raw[`SBHF_IN_FLUSH] = flush_b_pin;
	assign in_if.raw[`SBHF_IN_HOLD] = hold_pin;
	assign in_if.raw[`SBHF_IN_STROBE] = snoop_addr_strobe_b;
	assign in_if.raw[`SBHF_IN_ROLE] = redundancy_role_sel_b;

	sbhf_insync #(.W(`SBHF_IN_PINS)) u_sync (
		.clk(clk),
		.sif(in_if.sync)
	);

	logic flush_act;
	logic hold_act;
	logic strobe_act;
	logic role_chk;

	assign flush_act = ~in_if.clean[`SBHF_IN_FLUSH];
	assign hold_act = in_if.clean[`SBHF_IN_HOLD];
	assign strobe_act = ~in_if.clean[`SBHF_IN_STROBE];
	assign role_chk = ~in_if.clean[`SBHF_IN_ROLE];

	// straps caught at the first edge after reset release
	logic strap_done_q;
	logic tristate_q;
	logic checker_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_done_q <= `SBHF_RST_LOW;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tristate_q <= `SBHF_RST_LOW;
			checker_q <= `SBHF_RST_LOW;
		end else if (!strap_done_q) begin
			tristate_q <= flush_act;
			checker_q <= role_chk;
		end
	end

	assign tristate_test = tristate_q;
	assign checker_mode = checker_q;

	// inquire cycles
	logic strobe_prev_q;
	logic snoop_start;
	logic snoop_req_q;
	logic hit_b_q;
	logic snoop_hit_modified_out_b_q;
	logic snoop_hit_modified_out_d;
	logic run_ok;

	// one inquire per strobe assertion, address already on the pins
	// normal operation: straps taken and not in test mode
	assign run_ok = strap_done_q & ~tristate_q;
	assign snoop_start = strobe_act & ~strobe_prev_q & run_ok;
	assign snoop_lookup_req = snoop_start;
	// a new modified hit wins over a writeback finishing
	assign snoop_hit_modified_out_d = (snoop_req_q & snoop_lookup_hit_mod) |
		(~snoop_hit_modified_out_b_q & ~snoop_wb_done);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strobe_prev_q <= `SBHF_RST_LOW;
			snoop_req_q <= `SBHF_RST_LOW;
		end else begin
			strobe_prev_q <= strobe_act;
			snoop_req_q <= snoop_start;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hit_b_q <= `SBHF_RST_NEG_B;
		end else if (snoop_req_q) begin
			hit_b_q <= ~snoop_lookup_hit;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			snoop_hit_modified_out_b_q <= `SBHF_RST_NEG_B;
		end else begin
			snoop_hit_modified_out_b_q <= ~snoop_hit_modified_out_d;
		end
	end

	assign snoop_hit_b = hit_b_q;
	assign snoop_hit_modified_out_b = snoop_hit_modified_out_b_q;

	// fp error and branch trace
	logic fp_error_out_b_q;
	logic bt_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fp_error_out_b_q <= `SBHF_RST_NEG_B;
		end else begin
			fp_error_out_b_q <= ~fp_err_unmasked;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bt_q <= `SBHF_RST_LOW;
		end else begin
			bt_q <= branch_taken_evt;
		end
	end

	assign fp_error_out_b = fp_error_out_b_q;
	assign branch_taken_pulse = bt_q;

	// cache flush sequence
	sbhf_flush_t fl_q;
	sbhf_flush_t fl_d;

	always_comb begin
		fl_d = fl_q;
		unique case (fl_q)
			FL_IDLE: begin
				if (flush_act && run_ok) begin
					fl_d = FL_WB;
				end
			end
			FL_WB: begin
				if (flush_wb_done) begin
					fl_d = FL_INV;
				end
			end
			FL_INV: begin
				fl_d = FL_ACK;
			end
			FL_ACK: begin
				if (flush_ack_cyc_done) begin
					fl_d = FL_DONE;
				end
			end
			FL_DONE: begin
				if (!flush_act) begin
					fl_d = FL_IDLE;
				end
			end
			default: begin
				fl_d = FL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fl_q <= FL_IDLE;
		end else begin
			fl_q <= fl_d;
		end
	end

	assign flush_wb_req = (fl_q == FL_WB);
	assign cache_inv_req = (fl_q == FL_INV);
	assign flush_ack_cyc_req = (fl_q == FL_ACK);

	// bus hold handshake
	sbhf_hold_t hd_q;
	sbhf_hold_t hd_d;
	logic ack_q;
	logic hold_take;
	logic bus_quiet;
	logic ack_pin;

	function automatic logic ack_level(input logic run_b, input logic held,
		input logic req);
		return run_b ? held : req;
	endfunction

	// a locked sequence keeps the request from being recognised
	assign hold_take = hold_act & ~bus_locked;
	assign bus_quiet = ~bus_busy & ~bus_locked;

	always_comb begin
		hd_d = hd_q;
		unique case (hd_q)
			HD_IDLE: begin
				if (hold_take) begin
					hd_d = HD_WAIT;
				end
			end
			HD_WAIT: begin
				if (!hold_act) begin
					hd_d = HD_IDLE;
				end else if (bus_quiet) begin
					hd_d = HD_HELD;
				end
			end
			HD_HELD: begin
				if (!hold_act) begin
					hd_d = HD_IDLE;
				end
			end
			default: begin
				hd_d = HD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hd_q <= HD_IDLE;
			ack_q <= `SBHF_RST_LOW;
		end else begin
			hd_q <= hd_d;
			ack_q <= (hd_d == HD_HELD);
		end
	end

	// during reset the request is mirrored straight to the acknowledge
	assign ack_pin = ack_level(rst_b, ack_q, hold_act);
	assign bus_grant_ack = ack_pin;
	// new cycles may go out in the same clock the acknowledge drops
	assign bus_start_ok = rst_b & (hd_q == HD_IDLE) & ~hold_take &
		strap_done_q;

	// pin drive: checker mode floats everything but error pin, test mode floats all
	logic float_all;

	assign float_all = tristate_q | checker_q;
	assign snoop_hit_oe_b = float_all;
	assign snoop_snoop_hit_modified_out_oe_b = float_all;
	assign fp_error_oe_b = float_all;
	assign bus_grant_ack_oe_b = float_all;
	// not affected by hold, only by the role and test straps
	assign branch_taken_oe_b = float_all;
	assign internal_error_oe_b = tristate_q;
	assign bus_pins_oe_b = float_all | ack_pin;

	// redundancy check: pins sampled, compared one clock later
	logic [`SBHF_OWN_PINS-1:0] own_exp;
	logic [PW-1:0] exp_now;
	logic [PW-1:0] exp_q;
	logic [PW-1:0] pin_q;
	logic internal_error_out_b_q;
	logic chk_miss;

	assign own_exp[`SBHF_PIN_HIT] = hit_b_q;
	assign own_exp[`SBHF_PIN_SNOOP_HIT_MODIFIED_OUT] = snoop_hit_modified_out_b_q;
	assign own_exp[`SBHF_PIN_FP_ERROR_OUT] = fp_error_out_b_q;
	assign own_exp[`SBHF_PIN_ACK] = bus_grant_ack;
	assign own_exp[`SBHF_PIN_BT] = bt_q;
	assign exp_now = {core_pin_exp, own_exp};

	assign chk_miss = checker_q & (pin_q != exp_q);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			exp_q <= '0;
			pin_q <= '0;
		end else begin
			exp_q <= exp_now;
			pin_q <= {core_pin_in, own_pin_in};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			internal_error_out_b_q <= `SBHF_RST_NEG_B;
		end else begin
			internal_error_out_b_q <= ~chk_miss;
		end
	end

	assign internal_error_out_b = internal_error_out_b_q;
endmodule

// >>> sbhf_ctrl_properties.sv
`timescale 1ns/1ps
module sbhf_ctrl_properties #(
	parameter int CW = 8
) (
	input wire logic clk, // clock
	input wire logic rst_b, // reset
	input wire logic snoop_lookup_req, // lookup
	input wire logic snoop_lookup_hit, // hit
	input wire logic snoop_lookup_hit_mod, // modified
	input wire logic snoop_hit_b, // hit pin
	input wire logic snoop_hit_modified_out_b, // snoop_hit_modified_out pin
	input wire logic fp_err_unmasked, // fp error
	input wire logic fp_error_out_b, // fp pin
	input wire logic branch_taken_evt, // branch
	input wire logic branch_taken_pulse, // pulse
	input wire logic bus_locked, // lock
	input wire logic bus_grant_ack, // ack
	input wire logic bus_start_ok, // start
	input wire logic checker_mode, // role
	input wire logic internal_error_out_b, // error pin
	input wire logic [CW-1:0] core_pin_exp, // computed
	input wire logic [CW-1:0] core_pin_in // sampled
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_inq(r);
		snoop_lookup_req ##1 r;
	endsequence
	a_hit_two_clk: assert property (s_inq(snoop_lookup_hit) |=> !snoop_hit_b)
		else $error("hit late");
	a_miss_two_clk: assert property (s_inq(!snoop_lookup_hit) |=> snoop_hit_b)
		else $error("miss late");
	a_hit_holds: assert property ($changed(snoop_hit_b) |-> $past(snoop_lookup_req, 2))
		else $error("hit moved");
	a_snoop_hit_modified_out_set: assert property (s_inq(snoop_lookup_hit_mod) |=> !snoop_hit_modified_out_b)
		else $error("snoop_hit_modified_out late");
	a_fp_error_out_follow: assert property (fp_err_unmasked |=> !fp_error_out_b)
		else $error("fp pin late");
	a_branch_one: assert property ($past(rst_b) |-> branch_taken_pulse == $past(branch_taken_evt))
		else $error("branch pulse");
	a_lock_no_ack: assert property (bus_locked && !bus_grant_ack |=> !bus_grant_ack)
		else $error("ack in lock");
	a_ack_release: assert property ($fell(bus_grant_ack) && $past(rst_b) |-> bus_start_ok)
		else $error("no start");
	a_role_kept: assert property ($past(rst_b, 2) |-> $stable(checker_mode))
		else $error("role moved");
	a_mismatch_err: assert property (checker_mode && core_pin_exp != core_pin_in |-> ##2 !internal_error_out_b)
		else $error("no error");
endmodule
bind sbhf_ctrl sbhf_ctrl_properties #(.CW(CW)) chk_u (.clk, .rst_b,
	.snoop_lookup_req, .snoop_lookup_hit, .snoop_lookup_hit_mod, .snoop_hit_b,
	.snoop_hit_modified_out_b, .fp_err_unmasked, .fp_error_out_b,
	.branch_taken_evt, .branch_taken_pulse, .bus_locked, .bus_grant_ack,
	.bus_start_ok, .checker_mode, .internal_error_out_b, .core_pin_exp,
	.core_pin_in);

// >>> sbhf_core_model.sv
`timescale 1ns/1ps
module sbhf_core_model (
	input wire logic clk, // clock
	input wire logic rst_b, // reset
	input wire logic snoop_lookup_req, // lookup
	input wire logic flush_wb_req, // writeback
	input wire logic flush_ack_cyc_req, // ack cycle
	input wire logic hit_cfg, // answer hit
	input wire logic mod_cfg, // answer modified
	output logic snoop_lookup_hit, // hit
	output logic snoop_lookup_hit_mod, // modified
	output logic flush_wb_done, // pulse
	output logic flush_ack_cyc_done // pulse
);
	logic req_q;
	logic tog_q;
	logic [2:0] cnt_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_q <= 1'b0;
			tog_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			req_q <= snoop_lookup_req;
			tog_q <= ~tog_q;
			cnt_q <= (flush_wb_req | flush_ack_cyc_req) ? cnt_q + 3'h1 : 3'h0;
		end
	end
	// outside the answer cycle the lines toggle, never a stale answer
	assign snoop_lookup_hit = req_q ? hit_cfg : tog_q;
	assign snoop_lookup_hit_mod = req_q ? mod_cfg : ~tog_q;
	assign flush_wb_done = flush_wb_req && cnt_q == 3'h4;
	assign flush_ack_cyc_done = flush_ack_cyc_req && cnt_q == 3'h1;
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk, rst_b, flush_b_pin, hold_pin, snoop_addr_strobe_b;
	logic redundancy_role_sel_b, snoop_wb_done, bus_busy, bus_locked;
	logic fp_err_unmasked, branch_taken_evt, hit_cfg, mod_cfg;
	logic snoop_lookup_req, snoop_lookup_hit, snoop_lookup_hit_mod;
	logic flush_wb_req, flush_wb_done, cache_inv_req, flush_ack_cyc_req;
	logic flush_ack_cyc_done, bus_start_ok, bus_pins_oe_b, snoop_hit_b;
	logic snoop_hit_modified_out_b, fp_error_out_b, bus_grant_ack;
	logic branch_taken_pulse, branch_taken_oe_b, internal_error_out_b;
	logic tristate_test, checker_mode, snoop_hit_oe_b, internal_error_oe_b;
	logic snoop_snoop_hit_modified_out_oe_b, fp_error_oe_b, bus_grant_ack_oe_b;
	logic [7:0] core_pin_exp, core_pin_in;
	logic [4:0] own_pin_in;
	wire [4:0] mon = {flush_ack_cyc_req, cache_inv_req, flush_wb_req,
		snoop_lookup_req, bus_grant_ack};
	int n_errors = 0;
	int check_count = 0;
	assign own_pin_in = {branch_taken_pulse, bus_grant_ack, fp_error_out_b,
		snoop_hit_modified_out_b, snoop_hit_b};
	sbhf_ctrl #(.CW(8)) dut_u (.clk, .rst_b, .flush_b_pin, .hold_pin,
		.snoop_addr_strobe_b, .redundancy_role_sel_b, .snoop_lookup_req,
		.snoop_lookup_hit, .snoop_lookup_hit_mod, .snoop_wb_done,
		.flush_wb_req, .flush_wb_done, .cache_inv_req, .flush_ack_cyc_req,
		.flush_ack_cyc_done, .bus_busy, .bus_locked, .bus_start_ok,
		.bus_pins_oe_b, .fp_err_unmasked, .branch_taken_evt, .snoop_hit_b,
		.snoop_hit_oe_b, .snoop_hit_modified_out_b, .snoop_snoop_hit_modified_out_oe_b,
		.fp_error_out_b, .fp_error_oe_b, .bus_grant_ack,
		.bus_grant_ack_oe_b, .branch_taken_pulse, .branch_taken_oe_b,
		.internal_error_out_b, .internal_error_oe_b, .own_pin_in,
		.core_pin_exp, .core_pin_in, .tristate_test, .checker_mode);
	sbhf_core_model model_u (.clk, .rst_b, .snoop_lookup_req, .flush_wb_req,
		.flush_ack_cyc_req, .hit_cfg, .mod_cfg, .snoop_lookup_hit,
		.snoop_lookup_hit_mod, .flush_wb_done, .flush_ack_cyc_done);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wt(input int k, input logic v);
		for (int i = 0; i < 60; i++) begin
			if (mon[k] === v) return;
			@(negedge clk);
		end
		chk("wait", mon[k], v);
		if (mon[k] !== v) begin
			print_verdict;
		end
	endtask
	task automatic do_reset(input logic fl, input logic role);
		rst_b = 1'b0;
		flush_b_pin = fl;
		redundancy_role_sel_b = role;
		hold_pin = 1'b1;
		cyc(6);
		chk("ack in reset", bus_grant_ack, 1'b1);
		hold_pin = 1'b0;
		cyc(6);
		rst_b = 1'b1;
		cyc(1);
		chk("tristate", tristate_test, !fl);
		chk("checker", checker_mode, !role);
		flush_b_pin = 1'b1;
		cyc(5);
	endtask
	task automatic t_inquire(input logic h, input logic m);
		hit_cfg = h;
		mod_cfg = m;
		snoop_addr_strobe_b = 1'b0;
		wt(1, 1'b1);
		cyc(2);
		chk("hit", snoop_hit_b, !h);
		chk("snoop_hit_modified_out", snoop_hit_modified_out_b, !m);
		snoop_addr_strobe_b = 1'b1;
		cyc(8);
		chk("hit kept", snoop_hit_b, !h);
	endtask
	task automatic t_snoop_hit_modified_out_clear;
		chk("snoop_hit_modified_out kept", snoop_hit_modified_out_b, 1'b0);
		chk("snoop_hit_modified_out oe", snoop_snoop_hit_modified_out_oe_b, 1'b0);
		snoop_wb_done = 1'b1;
		cyc(1);
		snoop_wb_done = 1'b0;
		chk("snoop_hit_modified_out clear", snoop_hit_modified_out_b, 1'b1);
	endtask
	task automatic t_flush;
		flush_b_pin = 1'b0;
		wt(2, 1'b1);
		wt(3, 1'b1);
		chk("wb over", flush_wb_req, 1'b0);
		wt(4, 1'b1);
		wt(4, 1'b0);
		cyc(8);
		chk("no restart", flush_wb_req, 1'b0);
		flush_b_pin = 1'b1;
		cyc(6);
	endtask
	task automatic t_hold;
		bus_locked = 1'b1;
		hold_pin = 1'b1;
		cyc(10);
		chk("ack locked", bus_grant_ack, 1'b0);
		bus_busy = 1'b1;
		bus_locked = 1'b0;
		cyc(4);
		chk("ack busy", bus_grant_ack, 1'b0);
		bus_busy = 1'b0;
		wt(0, 1'b1);
		chk("float", bus_pins_oe_b, 1'b1);
		chk("no start", bus_start_ok, 1'b0);
		chk("ack oe", bus_grant_ack_oe_b, 1'b0);
		branch_taken_evt = 1'b1;
		cyc(1);
		branch_taken_evt = 1'b0;
		chk("branch", branch_taken_pulse, 1'b1);
		chk("branch oe", branch_taken_oe_b, 1'b0);
		cyc(1);
		chk("branch end", branch_taken_pulse, 1'b0);
		chk("ack kept", bus_grant_ack, 1'b1);
		hold_pin = 1'b0;
		wt(0, 1'b0);
		chk("start", bus_start_ok, 1'b1);
	endtask
	task automatic t_fp_error_out;
		fp_err_unmasked = 1'b1;
		cyc(1);
		chk("fp on", fp_error_out_b, 1'b0);
		fp_err_unmasked = 1'b0;
		cyc(1);
		chk("fp off", fp_error_out_b, 1'b1);
		chk("fp oe", fp_error_oe_b, 1'b0);
		core_pin_in = 8'ha5;
		cyc(2);
		chk("no error", internal_error_out_b, 1'b1);
		core_pin_in = core_pin_exp;
	endtask
	task automatic t_checker;
		do_reset(1'b1, 1'b0);
		chk("hit float", snoop_hit_oe_b, 1'b1);
		chk("err driven", internal_error_oe_b, 1'b0);
		chk("snoop_hit_modified_out float", snoop_snoop_hit_modified_out_oe_b, 1'b1);
		chk("fp float", fp_error_oe_b, 1'b1);
		chk("ack float", bus_grant_ack_oe_b, 1'b1);
		core_pin_in = 8'ha5;
		cyc(1);
		core_pin_in = core_pin_exp;
		cyc(1);
		chk("mismatch", internal_error_out_b, 1'b0);
		cyc(1);
		chk("match", internal_error_out_b, 1'b1);
	endtask
	initial begin
		{snoop_addr_strobe_b, snoop_wb_done, bus_busy, bus_locked} = 4'h8;
		{fp_err_unmasked, branch_taken_evt, hit_cfg, mod_cfg} = 4'h0;
		core_pin_exp = 8'h5a;
		core_pin_in = 8'h5a;
		do_reset(1'b1, 1'b1);
		chk("master", bus_pins_oe_b, 1'b0);
		t_fp_error_out;
		t_inquire(1'b1, 1'b0);
		t_inquire(1'b0, 1'b0);
		t_inquire(1'b1, 1'b1);
		t_snoop_hit_modified_out_clear;
		t_flush;
		t_hold;
		t_checker;
		do_reset(1'b0, 1'b1);
		chk("test float", bus_pins_oe_b, 1'b1);
		do_reset(1'b1, 1'b1);
		t_inquire(1'b1, 1'b0);
		print_verdict;
	end
endmodule
